/* include/ctu_defines.svh */
// register offsets, field positions, reset values and bus response codes of the charge-time unit
`ifndef CTU_DEFINES_SVH
`define CTU_DEFINES_SVH
`define CTU_ADDR_W 8
`define CTU_OFF_CTRL_HI 8'h00
`define CTU_OFF_CTRL_LO 8'h04
`define CTU_OFF_ICTRL 8'h08
`define CTU_OFF_IRQ_STAT 8'h0C
`define CTU_OFF_IRQ_CLR 8'h10
`define CTU_OFF_IRQ_EN 8'h14
`define CTU_OFF_STATUS 8'h18
`define CTU_REG_RESET 8'h00
`define CTU_HI_IMPL_MASK 8'hBF
`define CTU_HI_EN 7
`define CTU_HI_UNUSED 6
`define CTU_HI_SIDL 5
`define CTU_HI_DELAY 4
`define CTU_HI_GATE 3
`define CTU_HI_ORDER 2
`define CTU_HI_GND 1
`define CTU_HI_TRIG 0
`define CTU_LO_E2POL 7
`define CTU_LO_E2SEL_H 6
`define CTU_LO_E2SEL_L 5
`define CTU_LO_E1POL 4
`define CTU_LO_E1SEL_H 3
`define CTU_LO_E1SEL_L 2
`define CTU_LO_E2SEEN 1
`define CTU_LO_E1SEEN 0
`define CTU_IC_TRIM_H 7
`define CTU_IC_TRIM_L 2
`define CTU_IC_RNG_H 1
`define CTU_IC_RNG_L 0
`define CTU_RNG_OFF 2'h0
`define CTU_IRQ_W 3
`define CTU_IRQ_E1 0
`define CTU_IRQ_E2 1
`define CTU_IRQ_PULSE 2
`define CTU_RESP_OKAY 2'h0
`define CTU_RESP_SLVERR 2'h2
`endif

/* include/ctu_pkg.sv */
// types shared by the charge-time unit modules
package ctu_pkg;
  typedef enum logic [1:0] {
    CTU_SRC_CMP2 = 2'h0,
    CTU_SRC_ECMP = 2'h1,
    CTU_SRC_PIN_B = 2'h2,
    CTU_SRC_PIN_A = 2'h3
  } ctu_src_t;
endpackage

/* include/ctu_edge_if.sv */
// carrier between the control core and one edge detector
`timescale 1ns/1ps
interface ctu_edge_if;
  ctu_pkg::ctu_src_t sel;
  logic pol;
  logic [3:0] src;
  logic hit;
  modport cfg (output sel, output pol, output src, input hit);
  modport unit (input sel, input pol, input src, output hit);
endinterface

/* verilog/ctu_edge_unit.sv */
// source select and polarity edge detector for one edge channel
`timescale 1ns/1ps
`include "ctu_defines.svh"
module ctu_edge_unit (
  input wire logic aclk,
  input wire logic aresetn,
  ctu_edge_if.unit eif
);
  import ctu_pkg::*;
  logic cur;
  logic prev_q, prev_d;
  logic hit_q, hit_d;

  always_comb begin
    case (eif.sel)
      CTU_SRC_PIN_A: cur = eif.src[3];
      CTU_SRC_PIN_B: cur = eif.src[2];
      CTU_SRC_ECMP: cur = eif.src[1];
      CTU_SRC_CMP2: cur = eif.src[0];
      default: cur = 1'b0;
    endcase
    prev_d = cur;
    hit_d = eif.pol ? (cur & ~prev_q) : (~cur & prev_q);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      prev_q <= 1'b0;
      hit_q <= 1'b0;
    end else begin
      prev_q <= prev_d;
      hit_q <= hit_d;
    end
  end

  assign eif.hit = hit_q;
endmodule

/* verilog/ctu_irq.sv */
// sticky event status, enable and write-one-to-clear interrupt
`timescale 1ns/1ps
`include "ctu_defines.svh"
module ctu_irq (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [`CTU_IRQ_W-1:0] event_set,
  input wire logic clr_wr,
  input wire logic en_wr,
  input wire logic [`CTU_IRQ_W-1:0] wr_data,
  output logic [`CTU_IRQ_W-1:0] status,
  output logic [`CTU_IRQ_W-1:0] enable,
  output logic irq
);
  logic [`CTU_IRQ_W-1:0] stat_q, stat_d, en_q, en_d;
  logic irq_q, irq_d;

  always_comb begin
    stat_d = (stat_q & ~(clr_wr ? wr_data : '0)) | event_set;
    en_d = en_wr ? wr_data : en_q;
    irq_d = |(stat_d & en_d);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      stat_q <= '0;
      en_q <= '0;
      irq_q <= 1'b0;
    end else begin
      stat_q <= stat_d;
      en_q <= en_d;
      irq_q <= irq_d;
    end
  end

  assign status = stat_q;
  assign enable = en_q;
  assign irq = irq_q;
endmodule

/* verilog/ctu_top.sv */
// control core of the charge-time measurement unit with its AXI4-Lite register slave
//
// Implementation choices: the AXI4-Lite interface to the registers and the register addresses.
`timescale 1ns/1ps
`include "ctu_defines.svh"
module ctu_top (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [`CTU_ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [`CTU_ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic edge_input_pin_a,
  input wire logic edge_input_pin_b,
  input wire logic enhanced_compare_trigger,
  input wire logic second_compare_trigger,
  input wire logic comparator_trip,
  input wire logic idle_mode,
  input wire logic sleep_mode,
  output logic source_enable,
  output logic source_ground,
  output logic [1:0] current_range,
  output logic [5:0] current_trim,
  output logic delay_pulse_pin,
  output logic conversion_trigger,
  output logic irq
);
  import ctu_pkg::*;

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  logic [7:0] hi_q, hi_d, lo_q, lo_d, ic_q, ic_d;
  logic awready_q, awready_d, wready_q, wready_d;
  logic aw_got_q, aw_got_d, w_got_q, w_got_d;
  logic [`CTU_ADDR_W-1:0] waddr_q, waddr_d;
  logic [7:0] wdata_q, wdata_d;
  logic wstrb_q, wstrb_d;
  logic bvalid_q, bvalid_d;
  logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;
  logic arready_q, arready_d, rvalid_q, rvalid_d;
  logic [31:0] rdata_q, rdata_d;
  logic [1:0] pin_s1_q, pin_s2_q;
  logic trip_s1_q, trip_s2_q, trip_prev_q;
  logic src_en_q, src_en_d, gnd_q, gnd_d, pulse_q, pulse_d, conv_q, conv_d;
  logic [1:0] rng_q, rng_d;
  logic [5:0] trim_q, trim_d;
  logic wr_fire, wr_hi, wr_lo, wr_ic, wr_clr, wr_en, wr_ok, rd_fire;
  logic active, gate, e1_set, e2_set, charge, trip_rise;
  logic [`CTU_IRQ_W-1:0] irq_stat, irq_en, irq_ev;
  logic irq_w;

  ctu_edge_if e1_if ();
  ctu_edge_if e2_if ();

  // ------------------------------------------------------------
  // input synchronisers
  // ------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_s1_q <= 2'h0;
      pin_s2_q <= 2'h0;
      trip_s1_q <= 1'b0;
      trip_s2_q <= 1'b0;
      trip_prev_q <= 1'b0;
    end else begin
      pin_s1_q <= {edge_input_pin_a, edge_input_pin_b};
      pin_s2_q <= pin_s1_q;
      trip_s1_q <= comparator_trip;
      trip_s2_q <= trip_s1_q;
      trip_prev_q <= trip_s2_q;
    end
  end

  // ------------------------------------------------------------
  // edge channels
  // ------------------------------------------------------------
  assign e1_if.sel = ctu_src_t'(lo_q[`CTU_LO_E1SEL_H:`CTU_LO_E1SEL_L]);
  assign e1_if.pol = lo_q[`CTU_LO_E1POL];
  assign e1_if.src = {pin_s2_q, enhanced_compare_trigger, second_compare_trigger};
  assign e2_if.sel = ctu_src_t'(lo_q[`CTU_LO_E2SEL_H:`CTU_LO_E2SEL_L]);
  assign e2_if.pol = lo_q[`CTU_LO_E2POL];
  assign e2_if.src = {pin_s2_q, enhanced_compare_trigger, second_compare_trigger};

  ctu_edge_unit u_edge1 (.aclk(aclk), .aresetn(aresetn), .eif(e1_if));
  ctu_edge_unit u_edge2 (.aclk(aclk), .aresetn(aresetn), .eif(e2_if));

  // ------------------------------------------------------------
  // write channel
  // ------------------------------------------------------------
  always_comb begin
    awready_d = s_axi_awvalid & ~awready_q & ~aw_got_q & ~bvalid_q;
    wready_d = s_axi_wvalid & ~wready_q & ~w_got_q & ~bvalid_q;
    wr_fire = aw_got_q & w_got_q & ~bvalid_q;
    aw_got_d = (s_axi_awvalid & awready_q) | (aw_got_q & ~wr_fire);
    w_got_d = (s_axi_wvalid & wready_q) | (w_got_q & ~wr_fire);
    waddr_d = (s_axi_awvalid & awready_q) ? s_axi_awaddr : waddr_q;
    wdata_d = (s_axi_wvalid & wready_q) ? s_axi_wdata[7:0] : wdata_q;
    wstrb_d = (s_axi_wvalid & wready_q) ? s_axi_wstrb[0] : wstrb_q;
    wr_ok = 1'b1;
    case (waddr_q)
      `CTU_OFF_CTRL_HI, `CTU_OFF_CTRL_LO, `CTU_OFF_ICTRL, `CTU_OFF_IRQ_STAT,
      `CTU_OFF_IRQ_CLR, `CTU_OFF_IRQ_EN, `CTU_OFF_STATUS: wr_ok = 1'b1;
      default: wr_ok = 1'b0;
    endcase
    wr_hi = wr_fire & wstrb_q & (waddr_q == `CTU_OFF_CTRL_HI);
    wr_lo = wr_fire & wstrb_q & (waddr_q == `CTU_OFF_CTRL_LO);
    wr_ic = wr_fire & wstrb_q & (waddr_q == `CTU_OFF_ICTRL);
    wr_clr = wr_fire & wstrb_q & (waddr_q == `CTU_OFF_IRQ_CLR);
    wr_en = wr_fire & wstrb_q & (waddr_q == `CTU_OFF_IRQ_EN);
    bvalid_d = wr_fire | (bvalid_q & ~s_axi_bready);
    bresp_d = wr_fire ? (wr_ok ? `CTU_RESP_OKAY : `CTU_RESP_SLVERR) : bresp_q;
  end

  // ------------------------------------------------------------
  // read channel
  // ------------------------------------------------------------
  always_comb begin
    arready_d = s_axi_arvalid & ~arready_q & ~rvalid_q;
    rd_fire = s_axi_arvalid & arready_q;
    rvalid_d = rd_fire | (rvalid_q & ~s_axi_rready);
    rdata_d = rdata_q;
    rresp_d = rresp_q;
    if (rd_fire) begin
      rresp_d = `CTU_RESP_OKAY;
      case (s_axi_araddr)
        `CTU_OFF_CTRL_HI: rdata_d = {24'h0, hi_q};
        `CTU_OFF_CTRL_LO: rdata_d = {24'h0, lo_q};
        `CTU_OFF_ICTRL: rdata_d = {24'h0, ic_q};
        `CTU_OFF_IRQ_STAT: rdata_d = {29'h0, irq_stat};
        `CTU_OFF_IRQ_CLR: rdata_d = 32'h0;
        `CTU_OFF_IRQ_EN: rdata_d = {29'h0, irq_en};
        `CTU_OFF_STATUS: rdata_d = {28'h0, conv_q, pulse_q, src_en_q, active};
        default: begin
          rdata_d = 32'h0;
          rresp_d = `CTU_RESP_SLVERR;
        end
      endcase
    end
  end

  // ------------------------------------------------------------
  // control core
  // ------------------------------------------------------------
  always_comb begin
    active = hi_q[`CTU_HI_EN] & ~(hi_q[`CTU_HI_SIDL] & idle_mode);
    gate = active & hi_q[`CTU_HI_GATE];
    e1_set = gate & e1_if.hit;
    e2_set = gate & e2_if.hit & (~hi_q[`CTU_HI_ORDER] | lo_q[`CTU_LO_E1SEEN]);
    hi_d = wr_hi ? (wdata_q & `CTU_HI_IMPL_MASK) : hi_q;
    ic_d = wr_ic ? wdata_q : ic_q;
    lo_d = wr_lo ? wdata_q : lo_q;
    lo_d[`CTU_LO_E1SEEN] = lo_d[`CTU_LO_E1SEEN] | e1_set;
    lo_d[`CTU_LO_E2SEEN] = lo_d[`CTU_LO_E2SEEN] | e2_set;
    charge = active & ~sleep_mode & lo_q[`CTU_LO_E1SEEN] & ~lo_q[`CTU_LO_E2SEEN]
             & (ic_q[`CTU_IC_RNG_H:`CTU_IC_RNG_L] != `CTU_RNG_OFF);
    src_en_d = charge;
    rng_d = ic_q[`CTU_IC_RNG_H:`CTU_IC_RNG_L];
    trim_d = ic_q[`CTU_IC_TRIM_H:`CTU_IC_TRIM_L];
    gnd_d = hi_q[`CTU_HI_GND];
    trip_rise = trip_s2_q & ~trip_prev_q;
    pulse_d = active & hi_q[`CTU_HI_DELAY] & lo_q[`CTU_LO_E1SEEN] & trip_rise;
    conv_d = active & hi_q[`CTU_HI_TRIG] & e2_set;
    irq_ev = {pulse_d, e2_set, e1_set};
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      hi_q <= `CTU_REG_RESET;
      lo_q <= `CTU_REG_RESET;
      ic_q <= `CTU_REG_RESET;
      awready_q <= 1'b0;
      wready_q <= 1'b0;
      aw_got_q <= 1'b0;
      w_got_q <= 1'b0;
      waddr_q <= '0;
      wdata_q <= 8'h00;
      wstrb_q <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q <= `CTU_RESP_OKAY;
      arready_q <= 1'b0;
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0;
      rresp_q <= `CTU_RESP_OKAY;
      src_en_q <= 1'b0;
      gnd_q <= 1'b0;
      pulse_q <= 1'b0;
      conv_q <= 1'b0;
      rng_q <= `CTU_RNG_OFF;
      trim_q <= 6'h00;
    end else begin
      hi_q <= hi_d;
      lo_q <= lo_d;
      ic_q <= ic_d;
      awready_q <= awready_d;
      wready_q <= wready_d;
      aw_got_q <= aw_got_d;
      w_got_q <= w_got_d;
      waddr_q <= waddr_d;
      wdata_q <= wdata_d;
      wstrb_q <= wstrb_d;
      bvalid_q <= bvalid_d;
      bresp_q <= bresp_d;
      arready_q <= arready_d;
      rvalid_q <= rvalid_d;
      rdata_q <= rdata_d;
      rresp_q <= rresp_d;
      src_en_q <= src_en_d;
      gnd_q <= gnd_d;
      pulse_q <= pulse_d;
      conv_q <= conv_d;
      rng_q <= rng_d;
      trim_q <= trim_d;
    end
  end

  // ------------------------------------------------------------
  // interrupt
  // ------------------------------------------------------------
  ctu_irq u_irq (
    .aclk(aclk),
    .aresetn(aresetn),
    .event_set(irq_ev),
    .clr_wr(wr_clr),
    .en_wr(wr_en),
    .wr_data(wdata_q[`CTU_IRQ_W-1:0]),
    .status(irq_stat),
    .enable(irq_en),
    .irq(irq_w)
  );

  assign s_axi_awready = awready_q;
  assign s_axi_wready = wready_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_arready = arready_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;
  assign source_enable = src_en_q;
  assign source_ground = gnd_q;
  assign current_range = rng_q;
  assign current_trim = trim_q;
  assign delay_pulse_pin = pulse_q;
  assign conversion_trigger = conv_q;
  assign irq = irq_w;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  sequence s_e1_accept;
    gate && e1_if.hit;
  endsequence
  sequence s_trip_armed;
    active && hi_q[`CTU_HI_DELAY] && lo_q[`CTU_LO_E1SEEN] && trip_rise;
  endsequence

  property p_disabled_off;
    !hi_q[`CTU_HI_EN] |=> !src_en_q;
  endproperty
  a_disabled_off: assert property (p_disabled_off) else $error("source on while disabled");
  property p_idle_stop;
    (hi_q[`CTU_HI_SIDL] && idle_mode) |=> !src_en_q && !pulse_q;
  endproperty
  a_idle_stop: assert property (p_idle_stop) else $error("unit ran in idle");
  property p_delay_off;
    !hi_q[`CTU_HI_DELAY] |=> !pulse_q;
  endproperty
  a_delay_off: assert property (p_delay_off) else $error("pulse without delay gen");
  property p_gate_block;
    (!hi_q[`CTU_HI_GATE] && !wr_lo) |=> (lo_q[1:0] == $past(lo_q[1:0]));
  endproperty
  a_gate_block: assert property (p_gate_block) else $error("edge passed closed gate");
  property p_order;
    (hi_q[`CTU_HI_ORDER] && !lo_q[`CTU_LO_E1SEEN] && !lo_q[`CTU_LO_E2SEEN] && !wr_lo)
      |=> !lo_q[`CTU_LO_E2SEEN];
  endproperty
  a_order: assert property (p_order) else $error("edge 2 before edge 1");
  property p_ground;
    hi_q[`CTU_HI_GND] |=> source_ground ##1 (source_ground == $past(hi_q[`CTU_HI_GND]));
  endproperty
  a_ground: assert property (p_ground) else $error("ground not applied");
  property p_trig;
    conv_q |-> $past(hi_q[`CTU_HI_TRIG]) && $past(e2_set);
  endproperty
  a_trig: assert property (p_trig) else $error("trigger while disabled");
  property p_range_off;
    (ic_q[`CTU_IC_RNG_H:`CTU_IC_RNG_L] == `CTU_RNG_OFF) |=> !src_en_q;
  endproperty
  a_range_off: assert property (p_range_off) else $error("source on with range off");
  property p_sleep;
    sleep_mode |=> !src_en_q;
  endproperty
  a_sleep: assert property (p_sleep) else $error("source on in sleep");
  property p_pulse;
    s_trip_armed |=> pulse_q ##1 !pulse_q;
  endproperty
  a_pulse: assert property (p_pulse) else $error("delay pulse missing");
  property p_edge_set;
    s_e1_accept |=> lo_q[`CTU_LO_E1SEEN];
  endproperty
  a_edge_set: assert property (p_edge_set) else $error("edge 1 flag lost");
  property p_unused;
    wr_hi |=> !hi_q[`CTU_HI_UNUSED];
  endproperty
  a_unused: assert property (p_unused) else $error("unused bit stored");
endmodule

/* verif/ctu_analog_model.sv */
// behavioural far side: current source charging a capacitor up to a comparator trip
`timescale 1ns/1ps
module ctu_analog_model #(
  parameter int TRIP_LEVEL = 6
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic source_enable,
  input wire logic source_ground,
  output logic comparator_trip
);
  logic [7:0] charge_q;
  logic [7:0] charge_d;
  // ground drains the capacitor at once, charging saturates
  always_comb begin
    charge_d = charge_q;
    if (source_ground) begin
      charge_d = 8'h00;
    end else if (source_enable && charge_q != 8'hFF) begin
      charge_d = charge_q + 8'h01;
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      charge_q <= 8'h00;
    end else begin
      charge_q <= charge_d;
    end
  end
  assign comparator_trip = (charge_q >= TRIP_LEVEL);
endmodule

/* verif/charge_time_edge_control_bench.sv */
// self-checking bench of the charge-time unit control core
`timescale 1ns/1ps
`include "ctu_defines.svh"
module charge_time_edge_control_bench;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'h0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic pin_a = 1'b0, pin_b = 1'b0, ecmp = 1'b0, cmp2 = 1'b0, idle = 1'b0, sleep = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, trip, src_en, src_gnd, pulse, conv, irq;
  logic [1:0] bresp, rresp, rng, rs;
  logic [5:0] trim;
  logic [31:0] rdata, rv;
  int bad_count = 0, tests_run = 0, cycles = 0, conv_n = 0, pulse_n = 0;
  always #10 aclk = ~aclk;
  ctu_top uut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .edge_input_pin_a(pin_a), .edge_input_pin_b(pin_b), .enhanced_compare_trigger(ecmp),
    .second_compare_trigger(cmp2), .comparator_trip(trip), .idle_mode(idle),
    .sleep_mode(sleep), .source_enable(src_en), .source_ground(src_gnd),
    .current_range(rng), .current_trim(trim), .delay_pulse_pin(pulse),
    .conversion_trigger(conv), .irq(irq));
  ctu_analog_model u_model (.aclk(aclk), .aresetn(aresetn), .source_enable(src_en),
    .source_ground(src_gnd), .comparator_trip(trip));
  // ----------------------------------------
  // pulse counters and hang guard
  // ----------------------------------------
  always @(posedge aclk) begin
    cycles++;
    if (conv === 1'b1) conv_n++;
    if (pulse === 1'b1) pulse_n++;
    if (cycles == 20000) begin
      bad_count++;
      complete_run();
    end
  end
  task check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task complete_run;
    $display("comparisons %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // ----------------------------------------
  // register bus master
  // ----------------------------------------
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
    logic aw_ok, w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= {24'h000000, d};
    wstrb <= 4'hF;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(aw_ok && w_ok)) begin
      @(posedge aclk);
      if (awready === 1'b1) begin
        aw_ok = 1'b1;
        awvalid <= 1'b0;
      end
      if (wready === 1'b1) begin
        w_ok = 1'b1;
        wvalid <= 1'b0;
      end
    end
    while (bvalid !== 1'b1) @(posedge aclk);
    check(bresp, er);
    bready <= 1'b0;
  endtask
  task rdr(input logic [7:0] a);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready === 1'b1) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    rv = rdata;
    rs = rresp;
    rready <= 1'b0;
  endtask
  task cfg(input logic [7:0] hi, input logic [7:0] lo);
    wr(`CTU_OFF_CTRL_HI, hi, `CTU_RESP_OKAY);
    wr(`CTU_OFF_CTRL_LO, lo, `CTU_RESP_OKAY);
    repeat (6) @(posedge aclk);
    wr(`CTU_OFF_CTRL_LO, lo, `CTU_RESP_OKAY);
  endtask
  task pulse_src(input logic [1:0] s);
    @(posedge aclk);
    case (s)
      2'h0: cmp2 <= 1'b1;
      2'h1: ecmp <= 1'b1;
      2'h2: pin_b <= 1'b1;
      default: pin_a <= 1'b1;
    endcase
    repeat (3) @(posedge aclk);
    {pin_a, pin_b, ecmp, cmp2} <= 4'h0;
    repeat (8) @(posedge aclk);
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task t_regs;
    logic [7:0] offs [6];
    offs = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h14, 8'h18};
    foreach (offs[i]) begin
      rdr(offs[i]);
      check(rv, 32'h0);
    end
    rdr(8'h1C);
    check(rs, `CTU_RESP_SLVERR);
    wr(8'h1C, 8'h55, `CTU_RESP_SLVERR);
    wr(`CTU_OFF_CTRL_HI, 8'hFF, `CTU_RESP_OKAY);
    rdr(`CTU_OFF_CTRL_HI);
    check(rv, 32'hBF);
    wr(`CTU_OFF_CTRL_HI, 8'h00, `CTU_RESP_OKAY);
  endtask
  task t_sources;
    for (int s = 0; s < 4; s++) begin
      cfg(8'h88, 8'h10 | (8'(s) << 2));
      pulse_src(2'(s));
      rdr(`CTU_OFF_CTRL_LO);
      check(rv[0], 1'b1);
    end
    cfg(8'h80, 8'h1C);
    pulse_src(2'h3);
    rdr(`CTU_OFF_CTRL_LO);
    check(rv[0], 1'b0);
    cfg(8'h08, 8'h1C);
    pulse_src(2'h3);
    rdr(`CTU_OFF_CTRL_LO);
    check(rv[0], 1'b0);
    cfg(8'h88, 8'h0C);
    @(posedge aclk);
    pin_a <= 1'b1;
    rdr(`CTU_OFF_CTRL_LO);
    check(rv[0], 1'b0);
    pin_a <= 1'b0;
    repeat (8) @(posedge aclk);
    rdr(`CTU_OFF_CTRL_LO);
    check(rv[0], 1'b1);
  endtask
  task t_order;
    cfg(8'h8D, 8'h5C);
    pulse_src(2'h2);
    rdr(`CTU_OFF_CTRL_LO);
    check(rv[1:0], 2'h0);
    pulse_src(2'h3);
    rdr(`CTU_OFF_CTRL_LO);
    check(rv[1:0], 2'h1);
    pulse_src(2'h2);
    rdr(`CTU_OFF_CTRL_LO);
    check(rv[1:0], 2'h3);
    check(conv_n, 1);
    cfg(8'h89, 8'h5C);
    pulse_src(2'h2);
    rdr(`CTU_OFF_CTRL_LO);
    check(rv[1:0], 2'h2);
    cfg(8'h88, 8'h5C);
    pulse_src(2'h3);
    pulse_src(2'h2);
    check(conv_n, 2);
  endtask
  task t_source;
    wr(`CTU_OFF_ICTRL, 8'h85, `CTU_RESP_OKAY);
    repeat (3) @(posedge aclk);
    check(trim, 6'h21);
    check(rng, 2'h1);
    cfg(8'h80, 8'h00);
    wr(`CTU_OFF_CTRL_LO, 8'h01, `CTU_RESP_OKAY);
    repeat (3) @(posedge aclk);
    check(src_en, 1'b1);
    repeat (20) @(posedge aclk);
    check(pulse_n, 0);
    sleep <= 1'b1;
    repeat (3) @(posedge aclk);
    check(src_en, 1'b0);
    sleep <= 1'b0;
    idle <= 1'b1;
    repeat (3) @(posedge aclk);
    check(src_en, 1'b1);
    wr(`CTU_OFF_CTRL_HI, 8'hA0, `CTU_RESP_OKAY);
    repeat (3) @(posedge aclk);
    check(src_en, 1'b0);
    idle <= 1'b0;
    wr(`CTU_OFF_CTRL_LO, 8'h03, `CTU_RESP_OKAY);
    repeat (3) @(posedge aclk);
    check(src_en, 1'b0);
    wr(`CTU_OFF_CTRL_LO, 8'h01, `CTU_RESP_OKAY);
    wr(`CTU_OFF_ICTRL, 8'h7C, `CTU_RESP_OKAY);
    repeat (3) @(posedge aclk);
    check(src_en, 1'b0);
    check(trim, 6'h1F);
    wr(`CTU_OFF_CTRL_HI, 8'h02, `CTU_RESP_OKAY);
    repeat (3) @(posedge aclk);
    check(src_gnd, 1'b1);
  endtask
  task t_delay;
    wr(`CTU_OFF_ICTRL, 8'h01, `CTU_RESP_OKAY);
    wr(`CTU_OFF_CTRL_HI, 8'h90, `CTU_RESP_OKAY);
    repeat (2) @(posedge aclk);
    check(src_gnd, 1'b0);
    wr(`CTU_OFF_CTRL_LO, 8'h01, `CTU_RESP_OKAY);
    repeat (40) @(posedge aclk);
    check(pulse_n, 1);
    rdr(`CTU_OFF_STATUS);
    check(rv, 32'h3);
    rdr(`CTU_OFF_IRQ_STAT);
    check(rv[2], 1'b1);
    check(irq, 1'b0);
    wr(`CTU_OFF_IRQ_EN, 8'h04, `CTU_RESP_OKAY);
    repeat (3) @(posedge aclk);
    check(irq, 1'b1);
    wr(`CTU_OFF_IRQ_CLR, 8'h07, `CTU_RESP_OKAY);
    repeat (3) @(posedge aclk);
    check(irq, 1'b0);
  endtask
  task t_reset;
    wr(`CTU_OFF_CTRL_HI, 8'h82, `CTU_RESP_OKAY);
    wr(`CTU_OFF_ICTRL, 8'h7F, `CTU_RESP_OKAY);
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    check({src_gnd, src_en}, 2'h0);
    check({trim, rng}, 8'h00);
    rdr(`CTU_OFF_CTRL_HI);
    check(rv, 32'h0);
    rdr(`CTU_OFF_ICTRL);
    check(rv, 32'h0);
  endtask
  initial begin
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_regs();
    t_sources();
    t_order();
    t_source();
    t_delay();
    t_reset();
    complete_run();
  end
endmodule
